// >>> bench/dpi_defect_pad_test.sv
`timescale 1ns/1ps
module dpi_defect_pad_test;
    import dpi_pkg::*;
    typedef struct packed {
        logic wr;
        logic [9:0] param;
        logic slow;
        logic pad;
        logic ill;
    } dpi_row_t;
    logic core_clk = 0, rst_b = 0, start = 0, write_mode = 0, slow = 0, play = 0;
    logic [9:0] defect_param = '0;
    logic [11:0] n_par = '0, gap_at = '0;
    dpi_parcel_t host_in = '0, drive_in, drive_out, host_out;
    logic host_ready, drive_ready, busy, pad_active, param_illegal;
    logic [15:0] dq [0:2100];
    logic [15:0] hq [0:2100];
    int n_dq, n_hq, n_mismatch = 0, checks = 0;
    dpi_row_t rows [7] = '{'{1, 10'h001, 0, 1, 0}, '{1, 10'h1ff, 1, 1, 0}, '{1, 10'h204, 0, 0, 0},
        '{1, 10'h258, 1, 0, 1}, '{0, 10'h000, 0, 1, 0}, '{0, 10'h12c, 0, 1, 0}, '{0, 10'h204, 0, 0, 0}};
    always #12.5 core_clk = ~core_clk;
    dpi_drive_model dpi_drive_model_inst (.core_clk(core_clk), .rst_b(rst_b), .slow(slow), .play(play),
        .n_par(n_par), .gap_at(gap_at), .drive_ready(drive_ready), .drive_in(drive_in));
    dpi_defect_pad dpi_defect_pad_inst (.core_clk(core_clk), .rst_b(rst_b), .start(start),
        .write_mode(write_mode), .defect_param(defect_param), .host_in(host_in), .host_ready(host_ready),
        .drive_out(drive_out), .drive_ready(drive_ready), .drive_in(drive_in), .host_out(host_out),
        .busy(busy), .pad_active(pad_active), .param_illegal(param_illegal));
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wrap_up();
        if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    always @(posedge core_clk) begin
        if (host_in.valid && host_ready) host_in.data <= host_in.data + 16'h0001;
        if (drive_out.valid && n_dq < 2100) dq[n_dq] <= drive_out.data;
        if (drive_out.valid) n_dq <= n_dq + 1;
        if (host_out.valid && n_hq < 2100) hq[n_hq] <= host_out.data;
        if (host_out.valid) n_hq <= n_hq + 1;
        if (write_mode && pad_active && host_ready !== 1'b0) chk("host_ready", 16'h0000, 16'h0001);
    end
    task automatic run(input dpi_row_t r);
        int p4;
        p4 = 4 * r.param;
        n_dq = 0;
        n_hq = 0;
        @(posedge core_clk);
        write_mode <= r.wr;
        defect_param <= r.param;
        slow <= r.slow;
        host_in <= {r.wr, 16'h0000};
        n_par <= r.pad ? 12'd2066 : 12'd2048;
        gap_at <= r.pad ? p4[11:0] : 12'hfff;
        play <= !r.wr;
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        repeat (100) @(posedge core_clk);
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        repeat (10000) begin
            @(negedge core_clk);
            if (busy === 1'b0) break;
        end
        chk("out_count", r.wr ? 16'(2048 + 18 * r.pad) : 16'h0000, 16'(n_dq));
        chk("host_count", r.wr ? 16'h0000 : 16'd2048, 16'(n_hq));
        chk("illegal", 16'(r.ill), 16'(param_illegal));
        chk("last", r.wr ? 16'd2047 : 16'(2047 + 18 * r.pad), r.wr ? dq[n_dq - 1] : hq[2047]);
        for (int k = 0; k < 18 && r.wr && r.pad; k++) chk("pad", 16'(p4 - 1), dq[p4 + k]);
        if (r.pad) chk("resume", 16'(p4 + 18 * !r.wr), r.wr ? dq[p4 + 18] : hq[p4]);
        @(posedge core_clk);
        host_in.valid <= 1'b0;
        play <= 1'b0;
    endtask : run
    initial begin
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        foreach (rows[i]) run(rows[i]);
        @(posedge core_clk);
        write_mode <= 1'b1;
        host_in.valid <= 1'b1;
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        repeat (50) @(posedge core_clk);
        rst_b <= 1'b0;
        @(negedge core_clk);
        // RESET mid-run clears outputs
        chk("reset_busy", 16'h0000, 16'(busy));
        chk("reset_out", 16'h0000, 16'(drive_out.valid));
        @(posedge core_clk);
        rst_b <= 1'b1;
        host_in.valid <= 1'b0;
        run(rows[0]);
        wrap_up();
    end
    initial begin
        #(25 * 40000);
        n_mismatch++;
        wrap_up();
    end
endmodule : dpi_defect_pad_test

// >>> bench/dpi_drive_model.sv
`timescale 1ns/1ps
module dpi_drive_model
    import dpi_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic slow,
    input wire logic play,
    input wire logic [11:0] n_par,
    input wire logic [11:0] gap_at,
    output logic drive_ready,
    output dpi_parcel_t drive_in
);
    logic [11:0] idx;
    logic gapped;
    logic tog;
    // Slow drive takes every other cycle
    assign drive_ready = !slow || tog;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            idx <= '0;
            gapped <= 1'b0;
            tog <= 1'b0;
            drive_in <= '0;
        end else begin
            tog <= ~tog;
            if (play && idx < n_par && !(idx == gap_at && !gapped)) begin
                drive_in <= {1'b1, 4'h0, idx};
                idx <= idx + 12'h001;
            end else begin
                // Idle line never repeats the last value
                drive_in <= {1'b0, ~drive_in.data};
                gapped <= play && idx == gap_at;
                idx <= play ? idx : 12'h000;
            end
        end
    end
endmodule : dpi_drive_model

// >>> rtl/dpi_defect_pad.sv
`timescale 1ns/1ps
`include "dpi_map.svh"
// Summary of operation
// - Write inserts 18-parcel pad covering flaw
// - Defect parameter counts 8-byte (4-parcel) units
// - Parameter legal range zero to 516
// - Value 1004 octal means no flaw
// - Write start loads parameter, clears counter
// - Counter per parcel, word ignores low bits
// - Word match before sector end freezes counter, starts pad
// - Host stalled while write pad runs
// - Pad repeats previous parcel to drive
// - After pad, counter and host resume
// - Padded field grows into swallow area
// - Same pad position under both heads
// - Read start latches parameter, clears counter
// - Read pad parcels from drive discarded
// - After read pad, accept parcels again
module dpi_defect_pad
    import dpi_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic write_mode,
    input wire logic [9:0] defect_param,
    input wire dpi_parcel_t host_in,
    output logic host_ready,
    output dpi_parcel_t drive_out,
    input wire logic drive_ready,
    input wire dpi_parcel_t drive_in,
    output dpi_parcel_t host_out,
    output logic busy,
    output logic pad_active,
    output logic param_illegal
);
    dpi_state_t state;
    dpi_state_t next_state;
    logic is_write;
    logic [11:0] parcel_cnt;
    logic [4:0] defect_cnt;
    logic [15:0] last_parcel;
    logic [9:0] held_param;
    logic held_legal;
    logic load_hold;

    assign load_hold = (state == DPI_IDLE) && start;

    dpi_hold_reg u_hold (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .load(load_hold),
        .load_value(defect_param),
        .value(held_param),
        .legal(held_legal)
    );

    wire [9:0] word_cnt = parcel_cnt[11:2];
    wire word_phase0 = (parcel_cnt[1:0] == 2'b00);
    // no pad on max or illegal
    wire flaw_present = held_legal && (held_param != `DPI_NO_FLAW);
    wire sector_end = (parcel_cnt == `DPI_SECTOR_PARCELS);
    logic pad_done;
    wire hit = flaw_present && word_phase0 && (word_cnt == held_param) && !pad_done;
    wire w_step = host_in.valid && drive_ready;
    wire r_step = drive_in.valid;
    wire step = (state == DPI_XFER) && !hit && !sector_end && (is_write ? w_step : r_step);
    wire pad_step = (state == DPI_PAD) && (is_write ? drive_ready : r_step);
    wire pad_last = pad_step && (defect_cnt == 5'h01);
    // Match at sector end ends the field instead
    wire pad_start = (state == DPI_XFER) && hit && !sector_end;

    always_comb begin
        next_state = state;
        unique case (state)
            DPI_IDLE: if (start) next_state = DPI_XFER;
            DPI_XFER: begin
                if (sector_end) next_state = DPI_DONE;
                else if (hit) next_state = DPI_PAD;
            end
            DPI_PAD: if (pad_last) next_state = DPI_XFER;
            DPI_DONE: next_state = DPI_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= DPI_IDLE;
            is_write <= 1'b0;
            parcel_cnt <= 12'h000;
            defect_cnt <= 5'h00;
            pad_done <= 1'b0;
        end else begin
            state <= next_state;
            if (load_hold) begin
                is_write <= write_mode;
                parcel_cnt <= 12'h000;
                pad_done <= 1'b0;
            end else if (step) begin
                parcel_cnt <= parcel_cnt + 12'h001;
            end
            if (pad_start) begin
                defect_cnt <= `DPI_PAD_LEN;
            end else if (pad_step) begin
                defect_cnt <= defect_cnt - 5'h01;
            end
            if (pad_last) begin
                pad_done <= 1'b1;
            end
        end
    end

    assign host_ready = (state == DPI_XFER) && is_write && !hit && !sector_end && drive_ready;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            last_parcel <= 16'h0000;
            drive_out <= '0;
        end else begin
            drive_out.valid <= 1'b0;
            if (step && is_write) begin
                last_parcel <= host_in.data;
                drive_out <= '{valid: 1'b1, data: host_in.data};
            end else if (pad_step && is_write) begin
                drive_out <= '{valid: 1'b1, data: last_parcel};
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            host_out <= '0;
        end else begin
            host_out.valid <= step && !is_write;
            if (step && !is_write) begin
                host_out.data <= drive_in.data;
            end
        end
    end

    assign busy = (state != DPI_IDLE);
    assign pad_active = (state == DPI_PAD);
    assign param_illegal = !held_legal;

    // Pad parcels issued in this sector
    logic [4:0] pad_seen;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pad_seen <= 5'h00;
        end else if (load_hold) begin
            pad_seen <= 5'h00;
        end else if (pad_step) begin
            pad_seen <= pad_seen + 5'h01;
        end
    end

    a_pad_stall: assert property (@(posedge core_clk) disable iff (!rst_b)
        pad_active |-> !host_ready)
        else $error("host not stalled in pad");

    a_pad_load: assert property (@(posedge core_clk) disable iff (!rst_b)
        pad_start |=> (defect_cnt == `DPI_PAD_LEN && pad_active))
        else $error("pad count not eighteen");

    a_cnt_frozen: assert property (@(posedge core_clk) disable iff (!rst_b)
        pad_active |=> $stable(parcel_cnt))
        else $error("parcel counter moved in pad");

    a_read_drop: assert property (@(posedge core_clk) disable iff (!rst_b)
        (pad_active && !is_write) |=> !host_out.valid)
        else $error("pad parcel passed to host");

    a_pad_repeat: assert property (@(posedge core_clk) disable iff (!rst_b)
        (pad_step && is_write) |=> (drive_out.valid && drive_out.data == $past(last_parcel)))
        else $error("pad parcel not repeated");

    a_start_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
        load_hold |=> (parcel_cnt == 12'h000 && held_param == $past(defect_param)))
        else $error("start did not load");

    a_no_flaw: assert property (@(posedge core_clk) disable iff (!rst_b)
        (held_param == `DPI_NO_FLAW) |-> !hit)
        else $error("pad on flawless sector");

    a_pad_end: assert property (@(posedge core_clk) disable iff (!rst_b)
        pad_last |=> (state == DPI_XFER))
        else $error("transfer did not resume");

    a_read_start: assert property (@(posedge core_clk) disable iff (!rst_b)
        (load_hold && !write_mode) |=> (!is_write && parcel_cnt == 12'h000))
        else $error("read start not cleared");

    a_word_match: assert property (@(posedge core_clk) disable iff (!rst_b)
        hit |-> (parcel_cnt[11:2] == held_param && parcel_cnt[1:0] == 2'b00))
        else $error("pad off word boundary");

    a_cnt_step: assert property (@(posedge core_clk) disable iff (!rst_b)
        step |=> (parcel_cnt == $past(parcel_cnt) + 12'h001))
        else $error("parcel counter not advanced");

    a_cnt_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
        (state == DPI_XFER && !step) |=> $stable(parcel_cnt))
        else $error("parcel counter moved idle");

    a_pad_count: assert property (@(posedge core_clk) disable iff (!rst_b)
        pad_step |=> (defect_cnt == $past(defect_cnt) - 5'h01))
        else $error("pad counter not decremented");

    a_pad_len: assert property (@(posedge core_clk) disable iff (!rst_b)
        pad_seen <= `DPI_PAD_LEN)
        else $error("pad longer than eighteen");

    a_legal_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
        load_hold |=> (param_illegal == ($past(defect_param) > `DPI_DEFECT_MAX)))
        else $error("illegal flag wrong");

    a_illegal_nopad: assert property (@(posedge core_clk) disable iff (!rst_b)
        param_illegal |-> !hit)
        else $error("pad on illegal parameter");

    a_host_resume: assert property (@(posedge core_clk) disable iff (!rst_b)
        (pad_last && is_write) |=> (!drive_ready || host_ready))
        else $error("host not resumed");

    a_read_resume: assert property (@(posedge core_clk) disable iff (!rst_b)
        (pad_last && !is_write) ##1 r_step |=> host_out.valid)
        else $error("read not resumed");

    a_read_pass: assert property (@(posedge core_clk) disable iff (!rst_b)
        (step && !is_write) |=> (host_out.valid && host_out.data == $past(drive_in.data)))
        else $error("read parcel lost");

    a_write_pass: assert property (@(posedge core_clk) disable iff (!rst_b)
        (step && is_write) |=> (drive_out.valid && drive_out.data == $past(host_in.data)))
        else $error("write parcel lost");

    a_read_quiet: assert property (@(posedge core_clk) disable iff (!rst_b)
        (busy && !is_write) |=> !drive_out.valid)
        else $error("drive written in read");

    a_write_quiet: assert property (@(posedge core_clk) disable iff (!rst_b)
        is_write |=> !host_out.valid)
        else $error("host fed in write");

    a_pad_once: assert property (@(posedge core_clk) disable iff (!rst_b)
        pad_done |-> !hit)
        else $error("second pad in sector");

    a_done_idle: assert property (@(posedge core_clk) disable iff (!rst_b)
        (state == DPI_DONE) |=> (state == DPI_IDLE))
        else $error("sector did not close");

    a_sector_len: assert property (@(posedge core_clk) disable iff (!rst_b)
        sector_end |-> (!step && !host_ready))
        else $error("parcel past sector end");

    a_hit_stall: assert property (@(posedge core_clk) disable iff (!rst_b)
        hit |-> !host_ready)
        else $error("host not stalled at match");

    a_pad_wait: assert property (@(posedge core_clk) disable iff (!rst_b)
        (pad_active && is_write && !drive_ready) |=> !drive_out.valid)
        else $error("pad parcel without drive ready");

    a_pad_word: assert property (@(posedge core_clk) disable iff (!rst_b)
        pad_start |-> (parcel_cnt == {held_param, 2'b00}))
        else $error("pad at wrong word");

    c_write_pad: cover property (@(posedge core_clk) disable iff (!rst_b) pad_last && is_write);
    c_read_pad: cover property (@(posedge core_clk) disable iff (!rst_b) pad_last && !is_write);
    c_done: cover property (@(posedge core_clk) disable iff (!rst_b) state == DPI_DONE);
    c_illegal: cover property (@(posedge core_clk) disable iff (!rst_b) load_hold ##1 param_illegal);
    c_start_busy: cover property (@(posedge core_clk) disable iff (!rst_b) busy && start);
endmodule : dpi_defect_pad

// >>> rtl/dpi_hold_reg.sv
`timescale 1ns/1ps
`include "dpi_map.svh"
module dpi_hold_reg
    import dpi_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic load,
    input wire logic [9:0] load_value,
    output logic [9:0] value,
    output logic legal
);
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            value <= `DPI_NO_FLAW;
            legal <= 1'b1;
        end else if (load) begin
            value <= load_value;
            legal <= (load_value <= `DPI_DEFECT_MAX);
        end
    end
endmodule : dpi_hold_reg

// >>> rtl/dpi_map.svh
`ifndef DPI_MAP_SVH
`define DPI_MAP_SVH
`define DPI_DEFECT_W 10
`define DPI_DEFECT_MAX 10'h204
`define DPI_NO_FLAW 10'h204
`define DPI_PAD_LEN 5'h12
`define DPI_CNT_W 12
`define DPI_SECTOR_PARCELS 12'h0800
`define DPI_PARCEL_W 16
`endif

// >>> rtl/dpi_pkg.sv
package dpi_pkg;
    typedef enum logic [1:0] {
        DPI_IDLE = 2'b00,
        DPI_XFER = 2'b01,
        DPI_PAD = 2'b10,
        DPI_DONE = 2'b11
    } dpi_state_t;
    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } dpi_parcel_t;
endpackage : dpi_pkg
